// [inc/twm_regs.vh]
/*
 * Register map, field positions, reset values and output-action codes for the
 * timer waveform-mode control block.
 * Assumes an 8-bit register port with one-cycle read latency.
 */
`ifndef TWM_REGS_VH
`define TWM_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define TWM_ADDR_CTRL_A     8'h80
`define TWM_ADDR_CTRL_B     8'h81
`define TWM_ADDR_CMP_A_LO   8'h88
`define TWM_ADDR_CMP_A_HI   8'h89
`define TWM_ADDR_CMP_B_LO   8'h8A
`define TWM_ADDR_CMP_B_HI   8'h8B
`define TWM_ADDR_CAP_LO     8'h86
`define TWM_ADDR_CAP_HI     8'h87
`define TWM_ADDR_CNT_LO     8'h84
`define TWM_ADDR_CNT_HI     8'h85
`define TWM_ADDR_IRQ_STAT   8'h90
`define TWM_ADDR_IRQ_EN     8'h91
`define TWM_ADDR_IRQ_CLR    8'h92

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define TWM_CA_ACT_A_HI     7
`define TWM_CA_ACT_A_LO     6
`define TWM_CA_ACT_B_HI     5
`define TWM_CA_ACT_B_LO     4
`define TWM_CA_WRITE_MASK   8'hF3
`define TWM_CB_MODE_HI      4
`define TWM_CB_MODE_LO      3
`define TWM_CB_WRITE_MASK   8'h18
`define TWM_IRQ_MASK        8'h07
`define TWM_IRQ_OVF         0
`define TWM_IRQ_MATCH_A     1
`define TWM_IRQ_MATCH_B     2
`define TWM_CTRL_RESET      8'h00

// ----------------------------------------------------------------------------
// Counter limits and output-action codes
// ----------------------------------------------------------------------------
`define TWM_MAX             16'hFFFF
`define TWM_BOTTOM          16'h0000
`define TWM_TOP_8BIT        16'h00FF
`define TWM_TOP_9BIT        16'h01FF
`define TWM_TOP_10BIT       16'h03FF
`define TWM_ACT_OFF         2'h0
`define TWM_ACT_TOGGLE      2'h1
`define TWM_ACT_CLEAR       2'h2
`define TWM_ACT_SET         2'h3

`endif

// [verilog/twm_timer_wave_mode.v]
/*
 * Waveform-mode and compare-output control for a 16-bit timer/counter
 * with two compare channels. Holds control, compare, capture and count
 * registers, runs the counter on the I/O clock gated by a tick enable,
 * and drives the two waveform pins plus their override enables.
 * Assumes a single clock, a tick input already in this clock's domain,
 * and port-pin logic that applies the direction bit outside.
 */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "twm_regs.vh"

// Contract
// - Count on I/O clock, tick is enable
// - Nonzero action field overrides channel pin; code blocks PWM toggle codes except A in 14/15, 9/11
// - Action 00 disconnects output in all modes
// - Non-PWM: toggle, clear, set on match
// - Fast PWM: non-inverting and inverting at BOTTOM
// - Fast PWM toggle A only modes 14/15
// - Fast PWM compare equals TOP acts at TOP
// - Dual-slope: clear up, set down (inverted opposite)
// - Dual-slope toggle A only modes 9/11
// - Mode from control A low bits plus B
// - Modes 0,4,12: immediate update, flag at MAX
// - Phase-correct: update at TOP, flag at BOTTOM
// - Fast PWM: update at BOTTOM, flag at TOP
// - Modes 8/9: update and flag at BOTTOM
// - BOTTOM events mirror TOP timing
// - High mode bits in control B 4:3
// - Dual-slope compare BOTTOM low, TOP high
module twm_timer_wave_mode
(
    input  wire        clk,               // I/O clock, 25 MHz
    input  wire        arst_n,            // Asynchronous reset, active low
    input  wire        timer_tick_enable, // Selected timer tick, same domain
    input  wire [7:0]  reg_addr,          // Register address
    input  wire [7:0]  reg_wdata,         // Register write data
    input  wire        reg_wr,            // Write strobe
    input  wire        reg_rd,            // Read strobe
    output reg  [7:0]  reg_rdata,         // Read data, cycle after strobe
    output reg         wave_out_a,        // Channel A waveform level
    output reg         wave_out_b,        // Channel B waveform level
    output wire        wave_oe_a,         // Channel A overrides port pin
    output wire        wave_oe_b,         // Channel B overrides port pin
    output wire        irq                // Level interrupt
);

    // ------------------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------------------
    localparam [3:0] M_NORMAL = 4'h0;
    localparam [3:0] M_PC8    = 4'h1;
    localparam [3:0] M_PC9    = 4'h2;
    localparam [3:0] M_PC10   = 4'h3;
    localparam [3:0] M_CTC_A  = 4'h4;
    localparam [3:0] M_FP8    = 4'h5;
    localparam [3:0] M_FP9    = 4'h6;
    localparam [3:0] M_FP10   = 4'h7;
    localparam [3:0] M_PFC_C  = 4'h8;
    localparam [3:0] M_PFC_A  = 4'h9;
    localparam [3:0] M_PC_C   = 4'hA;
    localparam [3:0] M_PC_A   = 4'hB;
    localparam [3:0] M_CTC_C  = 4'hC;
    localparam [3:0] M_FP_C   = 4'hE;
    localparam [3:0] M_FP_A   = 4'hF;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [7:0]  ctrl_a_r;       // Output actions and low mode bits
    reg  [1:0]  mode_hi_r;      // High mode bits
    reg  [15:0] cmp_buf_a_r;    // Software-written compare A buffer
    reg  [15:0] cmp_buf_b_r;    // Software-written compare B buffer
    reg  [15:0] cmp_a_r;        // Active compare A
    reg  [15:0] cmp_b_r;        // Active compare B
    reg  [15:0] cap_r;          // Capture value, software written here
    reg  [15:0] cnt_r;          // Count value
    reg         down_r;         // Dual-slope direction, 1 = counting down
    reg  [2:0]  irq_stat_r;     // Sticky event bits
    reg  [2:0]  irq_en_r;       // Event enables
    reg  [15:0] cnt_nxt;        // Next count
    reg         down_nxt;       // Next direction
    reg  [15:0] top;            // Current TOP
    reg  [1:0]  kind;           // 0 non-PWM, 1 fast, 2 dual-slope
    reg         upd_now;        // Compare buffers load this tick
    reg         ovf_now;        // Overflow flag sets this tick

    wire [1:0]  act_a;          // Channel A output action
    wire [1:0]  act_b;          // Channel B output action
    wire [3:0]  wave_mode_sel;  // Combined waveform mode
    wire        at_top;         // Counter sits at TOP
    wire        at_bot;         // Counter sits at BOTTOM
    wire        match_a;        // Compare A equality
    wire        match_b;        // Compare B equality
    wire        cnt_wr;         // Software write to count blocks match

    assign act_a = ctrl_a_r[`TWM_CA_ACT_A_HI:`TWM_CA_ACT_A_LO];
    assign act_b = ctrl_a_r[`TWM_CA_ACT_B_HI:`TWM_CA_ACT_B_LO];
    assign wave_mode_sel = {mode_hi_r, ctrl_a_r[1:0]};
    assign at_top  = (cnt_r == top);
    assign at_bot  = (cnt_r == `TWM_BOTTOM);
    assign match_a = (cnt_r == cmp_a_r);
    assign match_b = (cnt_r == cmp_b_r);
    assign cnt_wr  = reg_wr && ((reg_addr == `TWM_ADDR_CNT_LO) || (reg_addr == `TWM_ADDR_CNT_HI));

    // ------------------------------------------------------------------------
    // Pin override: any nonzero action field takes over the pin, except toggle codes that PWM kinds block
    // ------------------------------------------------------------------------
    // Toggle code in PWM kinds only reaches channel A in modes 14/15 (fast PWM)
    // and 9/11 (dual-slope); everything else stays on the port.
    assign wave_oe_a = (act_a != `TWM_ACT_OFF) &&
                       !((act_a == `TWM_ACT_TOGGLE) &&
                         (((kind == 2'd1) && (wave_mode_sel != M_FP_C) && (wave_mode_sel != M_FP_A)) ||
                          ((kind == 2'd2) && (wave_mode_sel != M_PFC_A) && (wave_mode_sel != M_PC_A))));
    assign wave_oe_b = (act_b != `TWM_ACT_OFF) &&
                       !((act_b == `TWM_ACT_TOGGLE) && (kind != 2'd0));
    // Direction bit is applied by the port logic outside this block

    // ------------------------------------------------------------------------
    // Mode decode: TOP, waveform kind, update and flag points
    // ------------------------------------------------------------------------
    always @*
    begin
        top     = `TWM_MAX;
        kind    = 2'd0;
        upd_now = 1'b0;
        ovf_now = 1'b0;
        case (wave_mode_sel)
            M_NORMAL:
            begin
                ovf_now = (cnt_r == `TWM_MAX);
            end
            M_CTC_A, M_CTC_C:
            begin
                top     = (wave_mode_sel == M_CTC_A) ? cmp_a_r : cap_r;
                ovf_now = (cnt_r == `TWM_MAX);
            end
            M_PC8, M_PC9, M_PC10, M_PC_C, M_PC_A:
            begin
                case (wave_mode_sel)
                    M_PC8:   top = `TWM_TOP_8BIT;
                    M_PC9:   top = `TWM_TOP_9BIT;
                    M_PC10:  top = `TWM_TOP_10BIT;
                    M_PC_C:  top = cap_r;
                    default: top = cmp_a_r;
                endcase
                kind    = 2'd2;
                upd_now = at_top;
                ovf_now = at_bot && down_r;
            end
            M_FP8, M_FP9, M_FP10, M_FP_C, M_FP_A:
            begin
                case (wave_mode_sel)
                    M_FP8:   top = `TWM_TOP_8BIT;
                    M_FP9:   top = `TWM_TOP_9BIT;
                    M_FP10:  top = `TWM_TOP_10BIT;
                    M_FP_C:  top = cap_r;
                    default: top = cmp_a_r;
                endcase
                kind    = 2'd1;
                upd_now = at_bot;
                ovf_now = at_top;
            end
            M_PFC_C, M_PFC_A:
            begin
                top     = (wave_mode_sel == M_PFC_C) ? cap_r : cmp_a_r;
                kind    = 2'd2;
                upd_now = at_bot;
                ovf_now = at_bot && down_r;
            end
            default:                                              // Mode 13 reserved: counter idles
            begin
                top     = `TWM_MAX;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Next count and direction
    // ------------------------------------------------------------------------
    always @*
    begin
        cnt_nxt  = cnt_r + 16'h0001;
        down_nxt = down_r;
        if (kind == 2'd2)
        begin
            // Dual slope turns at TOP and at BOTTOM, each held one tick
            if (at_top)
            begin
                down_nxt = 1'b1;
                cnt_nxt  = cnt_r - 16'h0001;
            end
            else if (at_bot)
            begin
                down_nxt = 1'b0;
                cnt_nxt  = cnt_r + 16'h0001;
            end
            else if (down_r)
            begin
                cnt_nxt  = cnt_r - 16'h0001;
            end
        end
        else if (at_top)
        begin
            cnt_nxt  = `TWM_BOTTOM;
        end
        if (wave_mode_sel == 4'hD)
        begin
            cnt_nxt  = cnt_r;
        end
    end

    // ------------------------------------------------------------------------
    // Counter, compare update and waveform outputs
    // ------------------------------------------------------------------------
    // Count and outputs advance only on the tick, never on a derived clock; count writes and non-PWM compare loads act in any cycle.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r      <= 16'h0000;
            down_r     <= 1'b0;
            cmp_a_r    <= 16'h0000;
            cmp_b_r    <= 16'h0000;
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end
        else
        begin
            if (kind == 2'd0)
            begin
                // Non-PWM loads compare values at once
                cmp_a_r <= cmp_buf_a_r;
                cmp_b_r <= cmp_buf_b_r;
            end
            if (cnt_wr)
            begin
                cnt_r <= (reg_addr == `TWM_ADDR_CNT_LO) ? {cnt_r[15:8], reg_wdata}
                                                        : {reg_wdata, cnt_r[7:0]};
            end
            else if (timer_tick_enable)
            begin
                cnt_r  <= cnt_nxt;
                down_r <= down_nxt;
                if (upd_now)
                begin
                    cmp_a_r <= cmp_buf_a_r;
                    cmp_b_r <= cmp_buf_b_r;
                end
                wave_out_a <= wave_step(wave_out_a, act_a, match_a, 1'b1);
                wave_out_b <= wave_step(wave_out_b, act_b, match_b, 1'b0);
            end
        end
    end

    // One tick of the per-channel output action
    function wave_step;
        input       cur;
        input [1:0] act;
        input       mat;
        input       is_a;
        reg         nv;
        begin
            nv = cur;
            case (kind)
                2'd0:
                begin
                    if (mat)
                    begin
                        case (act)
                            `TWM_ACT_TOGGLE: nv = !cur;
                            `TWM_ACT_CLEAR:  nv = 1'b0;
                            `TWM_ACT_SET:    nv = 1'b1;
                            default:         nv = cur;
                        endcase
                    end
                end
                2'd1:
                begin
                    if (act[1])
                    begin
                        // Match at TOP is kept; the action lands at TOP
                        if (mat && !at_top)
                            nv = act[0];
                        else if (at_top && mat)
                            nv = act[0];
                        else if (at_bot)
                            nv = !act[0];
                    end
                    else if (act[0] && is_a && mat)
                        nv = !cur;
                end
                2'd2:
                begin
                    if (act[1])
                    begin
                        // Clear action: compare at BOTTOM never lifts, at TOP never drops
                        if (mat)
                            nv = (at_top || (down_r && !at_bot)) ? !act[0]
                                                                 : act[0];
                    end
                    else if (act[0] && is_a && mat)
                        nv = !cur;
                end
                default:
                begin
                    nv = cur;
                end
            endcase
            wave_step = nv;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Register writes and sticky events
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_a_r    <= `TWM_CTRL_RESET;
            mode_hi_r   <= 2'h0;
            cmp_buf_a_r <= 16'h0000;
            cmp_buf_b_r <= 16'h0000;
            cap_r       <= 16'h0000;
            irq_stat_r  <= 3'h0;
            irq_en_r    <= 3'h0;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `TWM_ADDR_CTRL_A:   ctrl_a_r <= reg_wdata & `TWM_CA_WRITE_MASK;
                    `TWM_ADDR_CTRL_B:   mode_hi_r <= reg_wdata[`TWM_CB_MODE_HI:`TWM_CB_MODE_LO];
                    `TWM_ADDR_CMP_A_LO: cmp_buf_a_r[7:0]  <= reg_wdata;
                    `TWM_ADDR_CMP_A_HI: cmp_buf_a_r[15:8] <= reg_wdata;
                    `TWM_ADDR_CMP_B_LO: cmp_buf_b_r[7:0]  <= reg_wdata;
                    `TWM_ADDR_CMP_B_HI: cmp_buf_b_r[15:8] <= reg_wdata;
                    `TWM_ADDR_CAP_LO:   cap_r[7:0]  <= reg_wdata;
                    `TWM_ADDR_CAP_HI:   cap_r[15:8] <= reg_wdata;
                    `TWM_ADDR_IRQ_EN:   irq_en_r <= reg_wdata[2:0];
                    default:            irq_en_r <= irq_en_r;
                endcase
            end
            // Clear first, then set, so a same-cycle event is kept
            if (reg_wr && (reg_addr == `TWM_ADDR_IRQ_CLR))
                irq_stat_r <= (irq_stat_r & ~reg_wdata[2:0]) | ev_set(1'b0);
            else
                irq_stat_r <= irq_stat_r | ev_set(1'b0);
        end
    end

    // Events of this tick; matches are blocked on a count write
    function [2:0] ev_set;
        input dummy_unused;
        begin
            ev_set = 3'h0;
            if (timer_tick_enable && !cnt_wr)
            begin
                ev_set[`TWM_IRQ_OVF]     = ovf_now;
                ev_set[`TWM_IRQ_MATCH_A] = match_a;
                ev_set[`TWM_IRQ_MATCH_B] = match_b;
            end
        end
    endfunction

    assign irq = |(irq_stat_r & irq_en_r);

    // ------------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TWM_ADDR_CTRL_A:   reg_rdata <= ctrl_a_r;
                `TWM_ADDR_CTRL_B:   reg_rdata <= {3'h0, mode_hi_r, 3'h0};
                `TWM_ADDR_CMP_A_LO: reg_rdata <= cmp_buf_a_r[7:0];
                `TWM_ADDR_CMP_A_HI: reg_rdata <= cmp_buf_a_r[15:8];
                `TWM_ADDR_CMP_B_LO: reg_rdata <= cmp_buf_b_r[7:0];
                `TWM_ADDR_CMP_B_HI: reg_rdata <= cmp_buf_b_r[15:8];
                `TWM_ADDR_CAP_LO:   reg_rdata <= cap_r[7:0];
                `TWM_ADDR_CAP_HI:   reg_rdata <= cap_r[15:8];
                `TWM_ADDR_CNT_LO:   reg_rdata <= cnt_r[7:0];
                `TWM_ADDR_CNT_HI:   reg_rdata <= cnt_r[15:8];
                `TWM_ADDR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_r};
                `TWM_ADDR_IRQ_EN:   reg_rdata <= {5'h00, irq_en_r};
                default:            reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule // twm_timer_wave_mode
`default_nettype wire

// [sim/twm_props.sv]
/*
 * Port checker for the timer waveform-mode block, bound to its top.
 * Assumes the register map of twm_regs.vh and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twm_regs.vh"
module twm_props
(
    input wire logic       clk,               // I/O clock
    input wire logic       arst_n,            // Async reset, active low
    input wire logic       timer_tick_enable, // Tick enable
    input wire logic [7:0] reg_addr,          // Register address
    input wire logic [7:0] reg_wdata,         // Write data
    input wire logic       reg_wr,            // Write strobe
    input wire logic       reg_rd,            // Read strobe
    input wire logic [7:0] reg_rdata,         // Read data
    input wire logic       wave_out_a,        // Channel A level
    input wire logic       wave_out_b,        // Channel B level
    input wire logic       wave_oe_a,         // Channel A override
    input wire logic       wave_oe_b,         // Channel B override
    input wire logic       irq                // Level interrupt
);
    // ------------------------------------------------------------------------
    // Shadow of what software wrote
    // ------------------------------------------------------------------------
    logic [7:0] ctl_a_r; // Control A as stored
    logic [7:0] ctl_b_r; // Control B as stored
    logic [7:0] en_r;    // Interrupt enable as stored

    // Mirror writes with the masks the block keeps
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl_a_r <= 8'h00;
            ctl_b_r <= 8'h00;
            en_r    <= 8'h00;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `TWM_ADDR_CTRL_A) ctl_a_r <= reg_wdata & `TWM_CA_WRITE_MASK;
            if (reg_addr == `TWM_ADDR_CTRL_B) ctl_b_r <= reg_wdata & `TWM_CB_WRITE_MASK;
            if (reg_addr == `TWM_ADDR_IRQ_EN) en_r <= reg_wdata & `TWM_IRQ_MASK;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    ctl_a_read_a: assert property (
        reg_rd && reg_addr == 8'h80 |=> reg_rdata == $past(ctl_a_r)) else $error("control A readback wrong");
    ctl_b_read_a: assert property (
        reg_rd && reg_addr == 8'h81 |=> reg_rdata == $past(ctl_b_r)) else $error("control B readback wrong");
    oe_a_off_a: assert property (
        ctl_a_r[7:6] == 2'h0 |-> !wave_oe_a) else $error("channel A pin taken while off");
    oe_b_off_a: assert property (
        ctl_a_r[5:4] == 2'h0 |-> !wave_oe_b) else $error("channel B pin taken while off");
    oe_a_on_a: assert property (
        ctl_a_r[7] |-> wave_oe_a) else $error("channel A pin not taken");
    oe_b_on_a: assert property (
        ctl_a_r[5] |-> wave_oe_b) else $error("channel B pin not taken");
    tick_hold_a: assert property (
        !timer_tick_enable && !reg_wr |=> $stable(wave_out_a) && $stable(wave_out_b))
        else $error("waveform moved without a tick");
    irq_mask_a: assert property ( // Masked interrupt stays low
        en_r == 8'h00 |-> !irq) else $error("interrupt raised while masked");
endmodule // twm_props

bind twm_timer_wave_mode twm_props i_twm_props (.clk(clk), .arst_n(arst_n),
    .timer_tick_enable(timer_tick_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .wave_oe_a(wave_oe_a), .wave_oe_b(wave_oe_b), .irq(irq));
`default_nettype wire

// [sim/twm_pin_model.sv]
/*
 * Port pin model standing beyond one waveform output.
 * Assumes override enable and level straight from the block.
 */
`timescale 1ns/1ps
`default_nettype none
module twm_pin_model
(
    input  wire logic dir_out,  // Direction bit, 1 = output
    input  wire logic port_val, // Normal port data
    input  wire logic wave,     // Waveform level
    input  wire logic wave_oe,  // Waveform override
    output wire logic pin       // Pad level
);
    // Driver stays off without the direction bit; the pad then sits at its pull-up
    assign pin = dir_out ? (wave_oe ? wave : port_val) : 1'b1;
endmodule // twm_pin_model
`default_nettype wire

// [sim/tb_timer_wave_mode_control.sv]
/*
 * Self-checking bench: counter model in integers, compared at quiet points.
 * Assumes the register map and one-cycle read latency of the block.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_timer_wave_mode_control;
    logic       clk = 1'b0, arst_n = 1'b0, tick = 1'b0, wstb = 1'b0, rstb = 1'b0, dir = 1'b1;
    logic [7:0] addr = 8'h00, wd = 8'h00, d, acts = 8'h79; // Action order: toggle, clear, set, toggle
    wire  [7:0] rdata;
    wire        wa, wb, oea, oeb, irq, pin_a;
    integer     fails = 0, check_count = 0, seed = 33, mcnt = 0, mup = 1, mode = 0, c = 0, i, r;

    always #20 clk = ~clk;

    twm_timer_wave_mode i_twm_timer_wave_mode (.clk(clk), .arst_n(arst_n), .timer_tick_enable(tick),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wstb), .reg_rd(rstb), .reg_rdata(rdata),
        .wave_out_a(wa), .wave_out_b(wb), .wave_oe_a(oea), .wave_oe_b(oeb), .irq(irq));
    twm_pin_model i_twm_pin_model (.dir_out(dir), .port_val(1'b0), .wave(wa), .wave_oe(oea), .pin(pin_a));

    // ------------------------------------------------------------------------
    // Bus, tick and model tasks
    // ------------------------------------------------------------------------
    task wr(input [7:0] a, input [7:0] v);
        @(posedge clk); addr <= a; wd <= v; wstb <= 1'b1;
        @(posedge clk); wstb <= 1'b0;
    endtask
    task rchk(input [7:0] a, input [7:0] e, input string n);
        @(posedge clk); addr <= a; rstb <= 1'b1;
        @(posedge clk); rstb <= 1'b0;
        @(negedge clk); `CHK(n, e, rdata)
    endtask
    // Count sequence per mode; dual slope dwells one tick at TOP and BOTTOM
    task step;
        case (mode)
            0: mcnt = (mcnt + 1) & 16'hFFFF;
            4: mcnt = (mcnt == c) ? 0 : mcnt + 1;
            5: mcnt = (mcnt == 255) ? 0 : mcnt + 1;
            default:
            begin
                if (mup && mcnt == 255) mup = 0;
                else if (!mup && mcnt == 0) mup = 1;
                mcnt = mup ? mcnt + 1 : mcnt - 1;
            end
        endcase
    endtask
    // Exactly n ticks, then the tick stops so outputs can be read at rest
    task run(input integer n);
        repeat (n) begin @(posedge clk); tick <= 1'b1; step; end
        @(posedge clk); tick <= 1'b0;
        @(negedge clk);
    endtask
    task finish_test;
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog well past the expected run length
    initial
    begin
        #(40 * 20000); fails++; finish_test;
    end

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rchk(8'h80, 8'h00, "ctrl_a_rst");
        rchk(8'h81, 8'h00, "ctrl_b_rst");
        // Every action code; reserved bits written with random junk
        for (i = 0; i < 4; i++)
        begin
            r = $random(seed);
            d = {i[1:0], i[1:0], r[3:2], 2'b00};
            wr(8'h80, d);
            rchk(8'h80, d & 8'hF3, "ctrl_a");
            `CHK("oe_a", (i != 0), oea)
            `CHK("oe_b", (i != 0), oeb)
        end
        `CHK("pin_drv", wa, pin_a)
        dir <= 1'b0; @(negedge clk);
        `CHK("pin_off", 1'b1, pin_a)
        wr(8'hFF, 8'hA5); wr(8'h81, 8'hFF);
        rchk(8'h81, 8'h18, "ctrl_b");
        rchk(8'h70, 8'h00, "unmapped");
        // Clear on match, TOP from compare A, random short period
        r = $random(seed); c = 8 + (r & 15);
        wr(8'h89, 8'h00); wr(8'h88, c[7:0]); wr(8'h81, 8'h08); wr(8'h80, 8'h00);
        wr(8'h85, 8'h00); wr(8'h84, 8'h00); mode = 4; mcnt = 0;
        run(c / 2);
        for (i = 0; i < 4; i++)
        begin
            wr(8'h80, {acts[2*i+:2], 6'h00});
            run(c + 1);
            `CHK("ctc_a", ~i[0], wa)
            rchk(8'h84, mcnt[7:0], "cnt_ctc");
        end
        // Fast PWM 8-bit: A non-inverting, B inverting
        wr(8'h8B, 8'h00); wr(8'h8A, 8'h40); wr(8'h88, 8'h40); wr(8'h81, 8'h08); wr(8'h80, 8'hB1);
        wr(8'h85, 8'h00); wr(8'h84, 8'h00); mode = 5; mcnt = 0;
        run(256 + 32);
        `CHK("fast_lo", 2'b10, {wa, wb})
        run(128);
        `CHK("fast_hi", 2'b01, {wa, wb})
        rchk(8'h84, mcnt[7:0], "cnt_fast");
        // Phase correct 8-bit, plus flags and interrupt
        wr(8'h81, 8'h00); wr(8'h80, 8'hB1); wr(8'h85, 8'h00); wr(8'h84, 8'h00); wr(8'h92, 8'h07);
        mode = 1; mcnt = 0; mup = 1;
        run(510 + 160);
        `CHK("pc_up", 2'b01, {wa, wb})
        rchk(8'h90, 8'h07, "status");
        wr(8'h91, 8'h01); @(negedge clk); `CHK("irq_on", 1'b1, irq)
        wr(8'h91, 8'h00); @(negedge clk); `CHK("irq_mask", 1'b0, irq)
        wr(8'h91, 8'h01); wr(8'h92, 8'h01); @(negedge clk); `CHK("irq_clr", 1'b0, irq)
        run(318);
        `CHK("pc_down", 2'b10, {wa, wb})
        rchk(8'h84, mcnt[7:0], "cnt_pc");
        finish_test;
    end
endmodule // tb_timer_wave_mode_control
`default_nettype wire
